// [hw/tieu_top.sv]
// Millisecond tick, interval timers and input edge interrupts
`timescale 1ns/1ps
module tieu_top #(
   parameter int unsigned TICK_CYCLES = tieu_pkg::TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_bank,
   input wire logic [7:0] cmd_param,
   input wire logic [31:0] cmd_value,
   input wire logic limit_left,
   input wire logic limit_right,
   input wire logic [4:0] gp_in,
   input wire logic irq_ack,
   output logic rsp_valid,
   output logic rsp_error,
   output logic [31:0] rsp_value,
   output logic irq_valid,
   output logic [7:0] irq_number
);

   // ------------------------------------------------------------
   // Local sizes
   // ------------------------------------------------------------
   localparam int unsigned PRE_W = $clog2(TICK_CYCLES);
   localparam int unsigned NT = tieu_pkg::NUM_TIMERS;
   localparam int unsigned NI = tieu_pkg::NUM_INPUTS;
   localparam int unsigned NS = tieu_pkg::NUM_SRC;
   localparam int unsigned IW = tieu_pkg::SRC_IDX_W;
   localparam int unsigned DW = tieu_pkg::DATA_W;
   localparam int unsigned EW = tieu_pkg::EDGE_W;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [PRE_W-1:0] pre_reg;            // Cycle prescaler
   logic ms_tick_reg;                    // One pulse per millisecond
   logic [DW-1:0] tick_count_reg;        // Millisecond counter
   logic [DW-1:0] period_reg [NT];       // Timer periods
   logic [EW-1:0] edge_sel_reg [NI];     // Input trigger codes
   logic [NI-1:0] in_raw;                // Raw input pins
   logic [NI-1:0] sync1_reg;             // First synchroniser stage
   logic [NI-1:0] sync2_reg;             // Second synchroniser stage
   logic [NI-1:0] prev_reg;              // Last synchronised level
   logic [NI-1:0] in_hit;                // Selected edge seen
   logic [NT-1:0] tmr_fire;              // Timer fire pulses
   logic [NS-1:0] evt;                   // All new events
   logic [NS-1:0] pending_reg;           // Held interrupts
   logic [NS-1:0] pending_next;
   logic [NS-1:0] ack_mask;              // Entry cleared by ack
   logic [IW-1:0] irq_idx_reg;           // Presented source index
   logic [IW-1:0] first_idx;             // Highest priority pending
   logic dec_hit;                        // Command addresses a parameter
   logic [DW-1:0] dec_rdata;             // Read value of that parameter
   logic tick_wr;                        // Tick counter write strobe
   logic [NT-1:0] per_wr;                // Period write strobes
   logic [NI-1:0] sel_wr;                // Trigger code write strobes
   logic cmd_set;                        // Accepted set command

   assign cmd_set = cmd_valid && cmd_write;
   assign in_raw = {gp_in, limit_right, limit_left};

   // ------------------------------------------------------------
   // Millisecond time base
   // ------------------------------------------------------------

   // Prescaler wraps once each millisecond
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pre_reg <= '0;
         ms_tick_reg <= 1'b0;
      end else if (pre_reg == PRE_W'(TICK_CYCLES - 1)) begin
         pre_reg <= '0;
         ms_tick_reg <= 1'b1;
      end else begin
         pre_reg <= pre_reg + PRE_W'(1);
         ms_tick_reg <= 1'b0;
      end
   end

   // Tick counter: a write takes priority over the increment
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tick_count_reg <= tieu_pkg::TICK_RST;
      end else if (tick_wr) begin
         tick_count_reg <= cmd_value;
      end else if (ms_tick_reg) begin
         tick_count_reg <= tick_count_reg + DW'(1);
      end
   end

   // ------------------------------------------------------------
   // Parameter decode
   // ------------------------------------------------------------

   // Bank and number select one parameter
   always_comb begin
      dec_hit = 1'b0;
      dec_rdata = '0;
      tick_wr = 1'b0;
      per_wr = '0;
      sel_wr = '0;
      if (cmd_bank == tieu_pkg::BANK_GLOBAL && cmd_param == tieu_pkg::PAR_TICK_COUNT) begin
         // Tick counter, readable at any time
         dec_hit = 1'b1;
         dec_rdata = tick_count_reg;
         tick_wr = cmd_set;
      end else if (cmd_bank == tieu_pkg::BANK_IRQ) begin
         // Interrupt parameters, numbered as their interrupts
         for (int t = 0; t < NT; t++) begin
            if (cmd_param == tieu_pkg::IRQ_NUM[t]) begin
               dec_hit = 1'b1;
               dec_rdata = period_reg[t];
               per_wr[t] = cmd_set;
            end
         end
         for (int j = 0; j < NI; j++) begin
            if (cmd_param == tieu_pkg::IRQ_NUM[NT + j]) begin
               dec_hit = 1'b1;
               dec_rdata = {{(DW - EW){1'b0}}, edge_sel_reg[j]};
               sel_wr[j] = cmd_set;
            end
         end
      end
   end

   // Reply one cycle after each command
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rsp_valid <= 1'b0;
         rsp_error <= 1'b0;
         rsp_value <= '0;
      end else begin
         rsp_valid <= cmd_valid;
         rsp_error <= cmd_valid && !dec_hit;
         if (!cmd_valid || !dec_hit) begin
            // Unknown parameter: no store, zero value
            rsp_value <= '0;
         end else if (cmd_write) begin
            rsp_value <= cmd_value;
         end else begin
            rsp_value <= dec_rdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Interval timers
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_tmr
         // Stored period of this timer
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               period_reg[g] <= tieu_pkg::PERIOD_RST;
            end else if (per_wr[g]) begin
               period_reg[g] <= cmd_value;
            end
         end

         tieu_interval_timer #(
            .WIDTH(DW)
         ) u_timer (
            .ref_clk(ref_clk),
            .rst(rst),
            .ms_tick(ms_tick_reg),
            .restart(per_wr[g]),
            .period(period_reg[g]),
            .fire(tmr_fire[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Input edge detection
   // ------------------------------------------------------------

   // Two-stage synchroniser, then one stage of history
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
         prev_reg <= '0;
      end else begin
         sync1_reg <= in_raw;
         sync2_reg <= sync1_reg;
         prev_reg <= sync2_reg;
      end
   end

   generate
      for (g = 0; g < NI; g++) begin : g_in
         // Trigger code of this input
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               edge_sel_reg[g] <= tieu_pkg::EDGE_RST;
            end else if (sel_wr[g]) begin
               edge_sel_reg[g] <= cmd_value[EW-1:0];
            end
         end

         // Low bit of the code arms rising, high bit falling
         assign in_hit[g] =
            (edge_sel_reg[g][0] && sync2_reg[g] && !prev_reg[g]) ||
            (edge_sel_reg[g][1] && !sync2_reg[g] && prev_reg[g]);

         chk_edge_rise: assert property (@(posedge ref_clk) disable iff (rst)
            (edge_sel_reg[g] == tieu_pkg::EDGE_RISE && sync2_reg[g] && !prev_reg[g])
            |=> pending_reg[NT + g])
            else $error("rising edge not held as pending");

         chk_edge_off: assert property (@(posedge ref_clk) disable iff (rst)
            (edge_sel_reg[g] == tieu_pkg::EDGE_OFF || (sync2_reg[g] == prev_reg[g]))
            |-> !in_hit[g])
            else $error("disabled or steady input raised an event");
      end
   endgenerate

   // ------------------------------------------------------------
   // Pending interrupts and priority
   // ------------------------------------------------------------
   assign evt = {in_hit, tmr_fire};

   // Lowest index is lowest interrupt number
   function automatic logic [IW-1:0] first_set(input logic [NS-1:0] v);
      logic [IW-1:0] r;
      r = '0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = IW'(i);
         end
      end
      return r;
   endfunction

   // Acknowledge clears only the presented source
   always_comb begin
      ack_mask = '0;
      if (irq_ack && irq_valid) begin
         ack_mask[irq_idx_reg] = 1'b1;
      end
   end

   // A new event wins over a clear in the same cycle
   assign pending_next = (pending_reg & ~ack_mask) | evt;
   assign first_idx = first_set(pending_next);

   // Hold all events and present the strongest one
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pending_reg <= '0;
         irq_valid <= 1'b0;
         irq_idx_reg <= '0;
         irq_number <= '0;
      end else begin
         pending_reg <= pending_next;
         irq_valid <= |pending_next;
         irq_idx_reg <= first_idx;
         irq_number <= tieu_pkg::IRQ_NUM[first_idx];
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_tick_advance: assert property (@(posedge ref_clk) disable iff (rst)
      (ms_tick_reg && !tick_wr) |=> tick_count_reg == $past(tick_count_reg) + DW'(1))
      else $error("tick counter missed a millisecond");

   chk_tick_hold: assert property (@(posedge ref_clk) disable iff (rst)
      (!ms_tick_reg && !tick_wr) |=> $stable(tick_count_reg))
      else $error("tick counter moved between milliseconds");

   chk_tick_period: assert property (@(posedge ref_clk) disable iff (rst)
      ms_tick_reg |-> pre_reg == '0 && $past(pre_reg) == PRE_W'(TICK_CYCLES - 1))
      else $error("millisecond pulse at wrong prescaler count");

   chk_tick_load: assert property (@(posedge ref_clk) disable iff (rst)
      tick_wr |=> tick_count_reg == $past(cmd_value))
      else $error("tick counter not loaded by write");

   chk_left_sel_wr: assert property (@(posedge ref_clk) disable iff (rst)
      (cmd_set && cmd_bank == tieu_pkg::BANK_IRQ && cmd_param == tieu_pkg::IRQ_NUM[NT])
      |=> edge_sel_reg[0] == $past(cmd_value[EW-1:0]))
      else $error("left limit trigger code not stored");

   chk_priority: assert property (@(posedge ref_clk) disable iff (rst)
      irq_valid |-> pending_reg[irq_idx_reg] &&
      ((pending_reg & ((NS'(1) << irq_idx_reg) - NS'(1))) == '0))
      else $error("presented interrupt is not the highest priority");

   chk_no_loss: assert property (@(posedge ref_clk) disable iff (rst)
      (irq_ack && irq_valid && evt[irq_idx_reg]) |=> pending_reg[$past(irq_idx_reg)])
      else $error("event lost on simultaneous acknowledge");

   chk_ack_clear: assert property (@(posedge ref_clk) disable iff (rst)
      (irq_ack && irq_valid && !evt[irq_idx_reg]) |=> !pending_reg[$past(irq_idx_reg)])
      else $error("acknowledged interrupt still pending");

   cov_tick_load: cover property (@(posedge ref_clk) disable iff (rst) tick_wr);
   cov_timer_fire: cover property (@(posedge ref_clk) disable iff (rst) tmr_fire[0]);
   cov_two_pending: cover property (@(posedge ref_clk) disable iff (rst)
      $countones(pending_reg) > 1);
   cov_ack: cover property (@(posedge ref_clk) disable iff (rst) irq_valid && irq_ack);

endmodule

// [hw/tieu_pkg.sv]
// Constants shared by the timer and input event unit
// Summary of operation
// - 32-bit counter advances once per millisecond
// - Writing tick counter reloads its starting value
// - Three periodic millisecond timers raise interrupts
// - Two-bit code selects off, rise, fall, both
// - Limit and general input triggers at fixed numbers
// - Lower interrupt number wins over higher ones
package tieu_pkg;

   // ------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------
   localparam int unsigned CLK_FREQ_HZ = 250_000_000; // Reference clock rate
   localparam int unsigned TICK_PERIOD_MS = 1;        // Tick period in ms
   localparam int unsigned MS_PER_S = 1000;
   // Clock cycles in one tick
   localparam int unsigned TICK_CYCLES = CLK_FREQ_HZ / MS_PER_S * TICK_PERIOD_MS;

   // ------------------------------------------------------------
   // Command fields
   // ------------------------------------------------------------
   localparam int unsigned DATA_W = 32;      // Parameter value width
   localparam int unsigned FIELD_W = 8;      // Bank and number width
   localparam logic [7:0] BANK_GLOBAL = 8'h00; // General parameter bank
   localparam logic [7:0] BANK_IRQ = 8'h03;    // Interrupt parameter bank
   localparam logic [7:0] PAR_TICK_COUNT = 8'h84; // Tick counter number

   // ------------------------------------------------------------
   // Edge selection codes
   // ------------------------------------------------------------
   localparam logic [1:0] EDGE_OFF = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;
   localparam int unsigned EDGE_W = 2;

   // ------------------------------------------------------------
   // Interrupt sources, in priority order
   // ------------------------------------------------------------
   localparam int unsigned NUM_TIMERS = 3;  // Periodic timers
   localparam int unsigned NUM_INPUTS = 7;  // Left, right, five general
   localparam int unsigned NUM_SRC = 10;    // All sources
   localparam int unsigned SRC_IDX_W = 4;   // Source index width
   // Interrupt number of each source; also its parameter number
   localparam logic [7:0] IRQ_NUM [NUM_SRC] = '{
      8'h00, 8'h01, 8'h02, 8'h1B, 8'h1C,
      8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B};

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] PERIOD_RST = 32'h0000_0000;
   localparam logic [31:0] TICK_RST = 32'h0000_0000;
   localparam logic [1:0] EDGE_RST = EDGE_OFF;

endpackage

// [hw/tieu_interval_timer.sv]
// One periodic millisecond interval timer
`timescale 1ns/1ps
module tieu_interval_timer #(
   parameter int unsigned WIDTH = 32
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic ms_tick,
   input wire logic restart,
   input wire logic [WIDTH-1:0] period,
   output logic fire
);

   // Elapsed milliseconds since last fire
   logic [WIDTH-1:0] count_reg;
   logic [WIDTH-1:0] count_next;

   // ------------------------------------------------------------
   // Period counting
   // ------------------------------------------------------------
   assign count_next = count_reg + WIDTH'(1);

   // A zero period keeps the timer idle; a new period restarts it
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         count_reg <= '0;
         fire <= 1'b0;
      end else if (restart) begin
         count_reg <= '0;
         fire <= 1'b0;
      end else if (ms_tick && period != '0) begin
         // Fire once each time the period elapses
         if (count_next >= period) begin
            count_reg <= '0;
            fire <= 1'b1;
         end else begin
            count_reg <= count_next;
            fire <= 1'b0;
         end
      end else begin
         fire <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   chk_fire_cause: assert property (@(posedge ref_clk) disable iff (rst)
      fire |-> $past(ms_tick) && $past(period) != '0 && !$past(restart))
      else $error("timer fired without a tick or with zero period");

   chk_fire_clears: assert property (@(posedge ref_clk) disable iff (rst)
      fire |-> count_reg == '0)
      else $error("timer count not cleared on fire");

endmodule

// [test/tieu_top_tb.sv]
// Self-checking testbench for the timer and input event unit
`timescale 1ns/1ps

`define CHK(g, e) check_val(32'(g), 32'(e))

module tieu_top_tb;

   // ------------------------------------------------------------
   // Signals and bench state
   // ------------------------------------------------------------
   localparam int TC = 8; // Shortened clock cycles per tick
   logic ref_clk; // Reference clock
   logic rst; // Synchronous reset
   logic cmd_valid;
   logic cmd_write;
   logic [7:0] cmd_bank;
   logic [7:0] cmd_param;
   logic [31:0] cmd_value;
   logic [6:0] pins; // Left, right, then five general inputs
   logic irq_ack;
   logic rsp_valid;
   logic rsp_error;
   logic [31:0] rsp_value;
   logic irq_valid;
   logic [7:0] irq_number;
   int failures; // Mismatch count
   int n_tests; // Comparison count
   int cyc = 0; // Free-running cycle count
   logic [31:0] mdl [int]; // Register model keyed by bank and number
   logic [7:0] exp_q [$]; // Interrupt numbers expected, in service order

   // ------------------------------------------------------------
   // Device under test
   // ------------------------------------------------------------
   tieu_top #(.TICK_CYCLES(TC)) dut (
      .ref_clk(ref_clk),
      .rst(rst),
      .cmd_valid(cmd_valid),
      .cmd_write(cmd_write),
      .cmd_bank(cmd_bank),
      .cmd_param(cmd_param),
      .cmd_value(cmd_value),
      .limit_left(pins[0]),
      .limit_right(pins[1]),
      .gp_in(pins[6:2]),
      .irq_ack(irq_ack),
      .rsp_valid(rsp_valid),
      .rsp_error(rsp_error),
      .rsp_value(rsp_value),
      .irq_valid(irq_valid),
      .irq_number(irq_number)
   );

   // Clock at 4 ns period
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   // Cycle counter for interval measurement
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
   end

   // ------------------------------------------------------------
   // Checking and closing
   // ------------------------------------------------------------
   // Compares one value, counts it, reports a mismatch at once
   task automatic check_val(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   // Prints the counts and the verdict, then stops
   task automatic report_and_stop();
      $display("compares=%0d mismatches=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // Command and interrupt tasks
   // ------------------------------------------------------------
   // One command, held for its taking edge; reply sampled next cycle
   task automatic cmd(input logic w, input logic [7:0] b, input logic [7:0] p,
                      input logic [31:0] v, output logic [31:0] rv, output logic re);
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_bank = b;
      cmd_param = p;
      cmd_value = v;
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      `CHK(rsp_valid, 1'b1);
      rv = rsp_value;
      re = rsp_error;
   endtask

   // Set parameter; model decides whether it is known and what it keeps
   task automatic setp(input logic [7:0] b, input logic [7:0] p, input logic [31:0] v);
      logic [31:0] rv;
      logic re;
      int k;
      k = int'({b, p});
      cmd(1'b1, b, p, v, rv, re);
      `CHK(re, !mdl.exists(k));
      `CHK(rv, mdl.exists(k) ? v : 32'h0000_0000);
      if (mdl.exists(k)) begin
         // Trigger codes keep two bits only
         mdl[k] = (b == 8'h03 && p > 8'h02) ? (v & 32'h0000_0003) : v;
      end
   endtask

   // Get parameter and compare with the model
   task automatic getp(input logic [7:0] b, input logic [7:0] p);
      logic [31:0] rv;
      logic re;
      int k;
      k = int'({b, p});
      cmd(1'b0, b, p, 32'h0000_0000, rv, re);
      `CHK(re, !mdl.exists(k));
      `CHK(rv, mdl.exists(k) ? mdl[k] : 32'h0000_0000);
   endtask

   // Serves interrupts for n cycles, checking each against the queue
   task automatic drain(input int n);
      repeat (n) begin
         @(posedge ref_clk);
         #1;
         if (irq_valid === 1'b1) begin
            `CHK(irq_number, exp_q.size() ? exp_q.pop_front() : 8'hFF);
            irq_ack = 1'b1;
         end else begin
            irq_ack = 1'b0;
         end
      end
      @(posedge ref_clk);
      #1;
      irq_ack = 1'b0;
      `CHK(exp_q.size(), 0);
   endtask

   // Waits for one interrupt, acknowledges it, returns its cycle
   task automatic wait_irq(input logic [7:0] num, output int at);
      int found;
      found = 0;
      at = 0;
      for (int i = 0; i < 200 && found == 0; i++) begin
         @(posedge ref_clk);
         #1;
         if (irq_valid === 1'b1) begin
            found = 1;
            at = cyc;
            `CHK(irq_number, num);
            irq_ack = 1'b1;
            @(posedge ref_clk);
            #1;
            irq_ack = 1'b0;
         end
      end
      `CHK(found, 1);
   endtask

   // ------------------------------------------------------------
   // Watchdog
   // ------------------------------------------------------------
   initial begin
      #(20000 * 4);
      failures++;
      report_and_stop();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r1;
      logic [31:0] r2;
      logic re;
      int a0;
      int a1;
      rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_bank = 8'h00;
      cmd_param = 8'h00;
      cmd_value = 32'h0000_0000;
      pins = 7'h00;
      irq_ack = 1'b0;
      failures = 0;
      n_tests = 0;
      void'($urandom(32'h474E));
      // Model holds every interrupt parameter at its zero reset value
      for (int i = 0; i < 10; i++) begin
         mdl[{8'h03, tieu_pkg::IRQ_NUM[i]}] = 32'h0000_0000;
      end
      mdl[{8'h00, 8'h84}] = 32'h0000_0000;
      repeat (2) @(posedge ref_clk);
      #1;
      rst = 1'b0;

      // Reset values, random read-back, unknown places
      for (int i = 0; i < 10; i++) begin
         getp(8'h03, tieu_pkg::IRQ_NUM[i]);
      end
      for (int i = 0; i < 10; i++) begin
         // Periods kept huge so no timer fires here
         setp(8'h03, tieu_pkg::IRQ_NUM[i], i < 3 ? ($urandom | 32'h8000_0000) : $urandom);
         getp(8'h03, tieu_pkg::IRQ_NUM[i]);
      end
      setp(8'h03, 8'h03, $urandom);
      setp(8'h01, 8'h00, $urandom);
      getp(8'h03, 8'h2C);
      getp(8'h00, 8'h85);
      for (int i = 0; i < 10; i++) begin
         setp(8'h03, tieu_pkg::IRQ_NUM[i], 32'h0000_0000);
      end
      `CHK(irq_valid, 1'b0);
      $display("test registers done");

      // Tick counter load, then exact count across a 32-bit wrap
      setp(8'h00, 8'h84, 32'hFFFF_FFFE);
      cmd(1'b0, 8'h00, 8'h84, 32'h0000_0000, r1, re);
      `CHK((r1 - 32'hFFFF_FFFE) <= 32'h1, 1'b1);
      repeat (4 * TC - 2) @(posedge ref_clk);
      cmd(1'b0, 8'h00, 8'h84, 32'h0000_0000, r2, re);
      `CHK(r2 - r1, 32'h0000_0004);
      $display("test tick done");

      // Each timer: interval of exactly its period, then disabled
      for (int t = 0; t < 3; t++) begin
         setp(8'h03, 8'(t), 32'(t + 2));
         wait_irq(8'(t), a0);
         wait_irq(8'(t), a1);
         `CHK(a1 - a0, (t + 2) * TC);
         setp(8'h03, 8'(t), 32'h0000_0000);
         drain(40);
      end
      $display("test timers done");

      // Every input with every edge code, rise then fall
      for (int s = 0; s < 7; s++) begin
         for (int c = 0; c < 4; c++) begin
            setp(8'h03, tieu_pkg::IRQ_NUM[s + 3], 32'(c));
            pins[s] = 1'b1;
            if (c[0]) exp_q.push_back(tieu_pkg::IRQ_NUM[s + 3]);
            drain(8);
            pins[s] = 1'b0;
            if (c[1]) exp_q.push_back(tieu_pkg::IRQ_NUM[s + 3]);
            drain(8);
         end
         setp(8'h03, tieu_pkg::IRQ_NUM[s + 3], 32'h0000_0000);
      end
      $display("test edges done");

      // All inputs at once: served one by one, lowest number first
      for (int s = 0; s < 7; s++) begin
         setp(8'h03, tieu_pkg::IRQ_NUM[s + 3], 32'(tieu_pkg::EDGE_BOTH));
      end
      for (int n = 0; n < 2; n++) begin
         pins = (n == 0) ? 7'h7F : 7'h00;
         for (int s = 0; s < 7; s++) begin
            exp_q.push_back(tieu_pkg::IRQ_NUM[s + 3]);
         end
         drain(20);
      end
      $display("test priority done");

      // Ack meets a new event of the same source: it stays pending
      setp(8'h03, 8'h00, 32'h0000_0001);
      a0 = 0;
      while (irq_valid !== 1'b1 && a0 < 40) begin
         @(posedge ref_clk);
         #1;
         a0++;
      end
      // Next fire of timer one millisecond later meets this ack
      repeat (TC - 1) @(posedge ref_clk);
      #1;
      irq_ack = 1'b1;
      @(posedge ref_clk);
      #1;
      irq_ack = 1'b0;
      `CHK(irq_valid, 1'b1);
      `CHK(irq_number, 8'h00);
      // Left limit edge joins while the timer is pending; timer first
      pins[0] = 1'b1;
      exp_q.push_back(8'h00);
      exp_q.push_back(tieu_pkg::IRQ_NUM[3]);
      setp(8'h03, 8'h00, 32'h0000_0000);
      drain(20);
      $display("test ack merge done");
      report_and_stop();
   end

endmodule
